// ### inc/fml_regs.svh
// Purpose: Constants of the flash muxed bus address latch
// Assumes: Included by the package and by the design modules
// Notes: Widths are the widest density; narrower parts mask upper bits
`ifndef FML_REGS_SVH
`define FML_REGS_SVH

// --------------------------------------------------------------
// Bus widths and field positions
// --------------------------------------------------------------
`define FML_AW 26
`define FML_DW 16
`define FML_HI_LSB 16
`define FML_UW 10
`define FML_CTRL_W 7
`define FML_SYNC_W 49

// --------------------------------------------------------------
// Topmost used address bit per density
// --------------------------------------------------------------
`define FML_TOP_128M 5'h16
`define FML_TOP_256M 5'h17
`define FML_TOP_512M 5'h18
`define FML_TOP_1G 5'h19

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define FML_ADDR_RST 26'h0000000
`define FML_DATA_RST 16'h0000
`define FML_UPPER_RST 10'h000

`endif

// ### inc/fml_pkg.sv
// Purpose: Types shared by the flash muxed bus address latch
// Assumes: fml_regs.svh supplies widths
// Notes: Pin groups travel as packed structs
`include "fml_regs.svh"

package fml_pkg;

	// --------------------------------------------------------------
	// Modes
	// --------------------------------------------------------------
	typedef enum logic [1:0] {FML_SPLIT, FML_AD_MUX, FML_TWO_PHASE} fml_bus_mode_t;
	typedef enum logic [1:0] {FML_D128M, FML_D256M, FML_D512M, FML_D1G} fml_density_t;

	// --------------------------------------------------------------
	// Carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic addr_strobe_n;
		logic upper_addr_strobe_n;
		logic frst_n;
		logic [`FML_AW-1:0] addr;
		logic [`FML_DW-1:0] ad;
	} fml_pins_t;

	typedef struct packed {
		fml_bus_mode_t bus_mode;
		logic sync_rd;
		logic rate133;
		fml_density_t density;
	} fml_cfg_t;

endpackage

// ### rtl/fml_sync.sv
// Purpose: Two-flop synchroniser bank
// Assumes: Inputs are asynchronous to clk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
`include "fml_regs.svh"

module fml_sync #(
	parameter int W = `FML_SYNC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import fml_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} fml_sync_state_t;

	fml_sync_state_t st_reg;
	fml_sync_state_t st_next;

	// --------------------------------------------------------------
	// Per-bit two stage chain
	// --------------------------------------------------------------
	genvar i;
	for (i = 0; i < W; i++)
	begin : g_bit
		always_comb
		begin
			st_next.meta[i] = d[i];
			st_next.stable[i] = st_reg.meta[i];
		end
	end

	// State register, constant reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign q = st_reg.stable;
endmodule // fml_sync

// ### rtl/fml_link_capture.sv
// Purpose: Synchronous address capture on the flash clock
// Assumes: Host launches pins relative to fclk rising edges
// Notes: Pins are already in this domain, so no synchroniser here
`timescale 1ns/100ps
`include "fml_regs.svh"

module fml_link_capture (
	input wire logic fclk,
	input wire logic rst_n,
	input fml_pkg::fml_pins_t pins,
	input fml_pkg::fml_cfg_t cfg,
	output logic [`FML_AW-1:0] addr_word,
	output logic cap_toggle
);
	import fml_pkg::*;

	typedef struct packed {
		logic got_first;
		logic pend_valid;
		logic [`FML_AW-1:0] pend_addr;
		logic [`FML_UW-1:0] upper;
		logic [`FML_AW-1:0] addr;
		logic tog;
	} fml_link_state_t;

	fml_link_state_t st_reg;
	fml_link_state_t st_next;
	logic active;
	logic [`FML_AW-1:0] low_addr;

	// --------------------------------------------------------------
	// Capture decisions
	// --------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		active = !pins.ce_n && pins.frst_n && cfg.sync_rd;
		case (cfg.bus_mode)
			FML_SPLIT: low_addr = pins.addr;
			FML_AD_MUX: low_addr = {pins.addr[`FML_AW-1:`FML_HI_LSB], pins.ad};
			FML_TWO_PHASE: low_addr = {st_reg.upper, pins.ad};
			default: low_addr = pins.addr;
		endcase
		if (!pins.frst_n)
		begin
			st_next.got_first = 1'b0;
			st_next.pend_valid = 1'b0;
		end
		else if (active)
		begin
			// Upper phase always precedes the lower one
			if (cfg.bus_mode == FML_TWO_PHASE && !pins.upper_addr_strobe_n)
				st_next.upper = pins.ad[`FML_UW-1:0];
			if (!pins.addr_strobe_n)
			begin
				if (cfg.rate133 && cfg.bus_mode != FML_TWO_PHASE)
				begin
					st_next.pend_addr = low_addr;
					st_next.pend_valid = 1'b1;
				end
				else if (!st_reg.got_first)
				begin
					st_next.addr = low_addr;
					st_next.tog = !st_reg.tog;
					st_next.got_first = 1'b1;
				end
			end
			else
			begin
				st_next.got_first = 1'b0;
				if (st_reg.pend_valid)
				begin
					st_next.addr = st_reg.pend_addr;
					st_next.tog = !st_reg.tog;
					st_next.pend_valid = 1'b0;
				end
			end
		end
	end

	// Rising edge of the flash clock only
	always_ff @(posedge fclk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign addr_word = st_reg.addr;
	assign cap_toggle = st_reg.tog;

	a_first_edge_capture: assert property (@(posedge fclk) disable iff (!rst_n)
		(active && !cfg.rate133 && !pins.addr_strobe_n && !st_reg.got_first)
		|=> (st_reg.tog != $past(st_reg.tog)) && (st_reg.addr == $past(low_addr)))
		else $error("first strobe edge did not capture address");
	a_last_edge_commit: assert property (@(posedge fclk) disable iff (!rst_n)
		(active && cfg.rate133 && cfg.bus_mode != FML_TWO_PHASE && !pins.addr_strobe_n)
		##1 (active && pins.addr_strobe_n) |=> (st_reg.addr == $past(low_addr, 2)))
		else $error("last low edge address not committed");
endmodule // fml_link_capture

// ### rtl/fml_flash_port.sv
// Purpose: Flash die parallel port: address latch, writes, data drive
// Assumes: Core logic on mclk; host bus timed to fclk or asynchronous
// Notes: Pin levels reach mclk logic only through two flops

`timescale 1ns/100ps
`include "fml_regs.svh"

// Summary of operation
// - 108 MHz sync read: address taken at first clock edge with strobe low.
// - 133 MHz sync read: address taken at last clock edge with strobe low.
// - Async split read: address flows through while strobe low, held at release.
// - Multiplexed read: host sends address, then device drives read data.
// - Shared lines float when deselected or output disabled.
// - Two-phase: upper strobe latches upper address, main strobe latches lower.
// - Two-phase sync read: address taken at first active clock edge.
// - Die select high: standby, data and wait outputs float.
// - Only rising flash clock edges are active.
// - Split bus: host writes on data lines, device drives reads, floats otherwise.
// - Address bits above the density's top bit are unused.
// - Output drivers enabled only while output enable is low.
// - Wait driven while selected and output enabled; signals data not valid.
// - Flash reset low clears operation and blocks writes.
module fml_flash_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic fclk,
	input fml_pkg::fml_pins_t pins,
	input fml_pkg::fml_cfg_t cfg,
	input wire logic [`FML_DW-1:0] rd_data,
	input wire logic rd_valid,
	output logic [`FML_AW-1:0] addr_out,
	output logic addr_stb,
	output logic [`FML_DW-1:0] wr_data,
	output logic wr_stb,
	output logic [`FML_DW-1:0] ad_o,
	output logic ad_oe,
	output logic wait_o,
	output logic wait_oe,
	output logic standby
);
	import fml_pkg::*;

	// Checks below all run on the core clock
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	typedef struct packed {
		logic adv_q;
		logic we_q;
		logic tog_q;
		logic [`FML_UW-1:0] upper;
		logic [`FML_AW-1:0] addr;
		logic addr_stb;
		logic [`FML_DW-1:0] wr_data;
		logic wr_stb;
		logic [`FML_DW-1:0] ad_o;
		logic ad_oe;
		logic wait_o;
		logic wait_oe;
		logic standby;
	} fml_port_state_t;

	localparam fml_port_state_t PORT_RST = '{
		adv_q: 1'b1, we_q: 1'b1, tog_q: 1'b0, upper: `FML_UPPER_RST,
		addr: `FML_ADDR_RST, addr_stb: 1'b0, wr_data: `FML_DATA_RST,
		wr_stb: 1'b0, ad_o: `FML_DATA_RST, ad_oe: 1'b0, wait_o: 1'b0,
		wait_oe: 1'b0, standby: 1'b1};

	fml_port_state_t st_reg;
	fml_port_state_t st_next;

	logic [`FML_AW-1:0] link_addr;
	logic link_tog;
	logic [`FML_SYNC_W-1:0] raw_bus;
	logic [`FML_SYNC_W-1:0] syn_bus;
	logic s_ce_n;
	logic s_oe_n;
	logic s_we_n;
	logic s_adv_n;
	logic s_upper_adv_n;
	logic s_frst_n;
	logic s_ce;
	logic s_oe;
	logic s_we;
	logic s_adv;
	logic s_upper_adv;
	logic s_frst;
	logic s_tog;
	logic [`FML_AW-1:0] s_addr;
	logic [`FML_DW-1:0] s_ad;
	logic [4:0] top_bit;
	logic [`FML_AW-1:0] top_mask;
	logic [`FML_AW-1:0] cur_addr;
	logic selected;
	logic drive;
	logic addr_phase_over;

	// --------------------------------------------------------------
	// Flash clock domain capture
	// --------------------------------------------------------------
	fml_link_capture u_link (
		.fclk(fclk),
		.rst_n(rst_n),
		.pins(pins),
		.cfg(cfg),
		.addr_word(link_addr),
		.cap_toggle(link_tog)
	);

	// --------------------------------------------------------------
	// Pin and toggle synchronisers
	// --------------------------------------------------------------
	// Toggle rides with the pins; captured word is stable by the time it lands
	// Strobes go in inverted so a cleared synchroniser reads as an idle bus
	assign raw_bus = {~pins.ce_n, ~pins.oe_n, ~pins.we_n, ~pins.addr_strobe_n,
		~pins.upper_addr_strobe_n, ~pins.frst_n, link_tog, pins.addr, pins.ad};

	fml_sync #(
		.W(`FML_SYNC_W)
	) u_sync (
		.clk(mclk),
		.rst_n(rst_n),
		.d(raw_bus),
		.q(syn_bus)
	);

	assign {s_ce, s_oe, s_we, s_adv, s_upper_adv, s_frst, s_tog,
		s_addr, s_ad} = syn_bus;

	// Back to pin polarity; avoids a false select and wait drive after reset
	assign s_ce_n = !s_ce;
	assign s_oe_n = !s_oe;
	assign s_we_n = !s_we;
	assign s_adv_n = !s_adv;
	assign s_upper_adv_n = !s_upper_adv;
	assign s_frst_n = !s_frst;

	// --------------------------------------------------------------
	// Density mask
	// --------------------------------------------------------------
	// Top used bit per density
	always_comb
	begin
		case (cfg.density)
			FML_D128M: top_bit = `FML_TOP_128M;
			FML_D256M: top_bit = `FML_TOP_256M;
			FML_D512M: top_bit = `FML_TOP_512M;
			FML_D1G: top_bit = `FML_TOP_1G;
			default: top_bit = `FML_TOP_1G;
		endcase
	end

	genvar b;
	for (b = 0; b < `FML_AW; b++)
	begin : g_mask
		assign top_mask[b] = (5'(b) <= top_bit);
	end

	// --------------------------------------------------------------
	// Asynchronous-path address assembly
	// --------------------------------------------------------------
	always_comb
	begin
		case (cfg.bus_mode)
			FML_SPLIT: cur_addr = s_addr;
			FML_AD_MUX: cur_addr = {s_addr[`FML_AW-1:`FML_HI_LSB], s_ad};
			FML_TWO_PHASE: cur_addr = {st_reg.upper, s_ad};
			default: cur_addr = s_addr;
		endcase
	end

	// Drive only after the address phase so host and device never fight
	assign selected = !s_ce_n;
	assign addr_phase_over = (cfg.bus_mode == FML_SPLIT) ||
		(s_adv_n && s_upper_adv_n);
	assign drive = selected && !s_oe_n && s_frst_n && s_we_n && addr_phase_over;

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		st_next.adv_q = s_adv_n;
		st_next.we_q = s_we_n;
		st_next.tog_q = s_tog;
		st_next.addr_stb = 1'b0;
		st_next.wr_stb = 1'b0;
		if (!s_frst_n)
		begin
			// Flash reset: drop in-flight latch state, ignore writes
			st_next.addr = `FML_ADDR_RST;
			st_next.upper = `FML_UPPER_RST;
		end
		else
		begin
			// Upper half from the shared lines in two-phase mode
			if (cfg.bus_mode == FML_TWO_PHASE && selected && !s_upper_adv_n)
				st_next.upper = s_ad[`FML_UW-1:0];
			if (cfg.sync_rd)
			begin
				// Word captured on fclk, announced by the toggle
				if (s_tog != st_reg.tog_q)
				begin
					st_next.addr = link_addr & top_mask;
					st_next.addr_stb = 1'b1;
				end
			end
			else if (selected)
			begin
				// Transparent while low, held from the release
				if (!s_adv_n)
					st_next.addr = cur_addr & top_mask;
				if (!st_reg.adv_q && s_adv_n)
					st_next.addr_stb = 1'b1;
			end
			// Word on the lines at the write strobe's release
			if (selected && !st_reg.we_q && s_we_n)
			begin
				st_next.wr_data = s_ad;
				st_next.wr_stb = 1'b1;
			end
		end
		// Output drive and float control
		st_next.ad_oe = drive;
		st_next.ad_o = drive ? rd_data : `FML_DATA_RST;
		// Wait enable follows select and output enable only; wait level also follows rd_valid
		st_next.wait_oe = selected && !s_oe_n;
		st_next.wait_o = selected && !s_oe_n && !rd_valid;
		st_next.standby = s_ce_n;
	end

	// State register
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= PORT_RST;
		else
			st_reg <= st_next;
	end

	// --------------------------------------------------------------
	// Outputs, all from flops
	// --------------------------------------------------------------
	assign addr_out = st_reg.addr;
	assign addr_stb = st_reg.addr_stb;
	assign wr_data = st_reg.wr_data;
	assign wr_stb = st_reg.wr_stb;
	assign ad_o = st_reg.ad_o;
	assign ad_oe = st_reg.ad_oe;
	assign wait_o = st_reg.wait_o;
	assign wait_oe = st_reg.wait_oe;
	assign standby = st_reg.standby;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	a_float_deselect: assert property (s_ce_n |=> !ad_oe && !wait_oe)
		else $error("lines driven while deselected");
	a_float_oe_high: assert property (s_oe_n |=> !ad_oe)
		else $error("lines driven while output disabled");
	a_standby_follow: assert property (s_ce_n |=> standby ##1 (standby || !s_ce_n))
		else $error("standby not shown while deselected");
	a_wait_drive: assert property ((selected && !s_oe_n && !rd_valid) |=> wait_oe && wait_o)
		else $error("wait not driven as not valid");
	a_reset_no_write: assert property (!s_frst_n |=> !wr_stb)
		else $error("write accepted during flash reset");
	a_async_flow: assert property ((!cfg.sync_rd && selected && s_frst_n && !s_adv_n)
		|=> addr_out == $past(cur_addr & top_mask))
		else $error("address not flowing through");
	a_sync_cross: assert property ((cfg.sync_rd && s_frst_n && s_tog != st_reg.tog_q)
		|=> addr_stb && addr_out == $past(link_addr & top_mask))
		else $error("captured address lost in crossing");
	a_mux_turnaround: assert property ((cfg.bus_mode != FML_SPLIT && !s_adv_n) |=> !ad_oe)
		else $error("device drove lines in address phase");
	a_top_bit: assert property (addr_stb |-> (addr_out & ~top_mask) == '0)
		else $error("address bit above density top set");
	a_write_capture: assert property ((selected && s_frst_n && !st_reg.we_q && s_we_n)
		|=> wr_stb && wr_data == $past(s_ad))
		else $error("write word not captured");

	// Address release, upper latch, drive, float, standby and flash reset at the pins
	a_async_release: assert property ((!cfg.sync_rd && selected && s_frst_n
		&& !st_reg.adv_q && s_adv_n) |=> addr_stb && $stable(addr_out))
		else $error("address not held at strobe release");
	a_upper_latch: assert property ((cfg.bus_mode == FML_TWO_PHASE && selected
		&& s_frst_n && !s_upper_adv_n) |=> st_reg.upper == $past(s_ad[`FML_UW-1:0]))
		else $error("upper address not latched");
	a_drive_data: assert property (ad_oe |-> ad_o == $past(rd_data))
		else $error("driven word is not the read word");
	a_no_drive_write: assert property (!s_we_n |=> !ad_oe)
		else $error("lines driven during a write");
	a_wait_float: assert property ((s_ce_n || s_oe_n) |=> !wait_oe && !wait_o)
		else $error("wait driven while not selected and enabled");
	a_standby_low: assert property (!s_ce_n |=> !standby)
		else $error("standby shown while selected");
	a_reset_clears: assert property (!s_frst_n |=> addr_out == `FML_ADDR_RST && !addr_stb)
		else $error("flash reset did not clear the address");
endmodule // fml_flash_port

// ### tb/fml_host_model.sv
// Purpose: Host memory controller model driving the flash pins
// Assumes: Pins change just after mclk rising edges
// Notes: Link clock runs only inside frames and while the bench holds reset, and idles low
`timescale 1ns/100ps
`include "fml_regs.svh"

module fml_host_model (
	input wire logic mclk,
	output fml_pkg::fml_pins_t pins,
	output logic fclk
);
	import fml_pkg::*;

	// --------------------------------------------------------------
	// Link clock and pin drive
	// --------------------------------------------------------------
	logic fclk_run;

	// Odd phase offset keeps fclk edges off mclk edges
	initial
	begin
		fclk = 1'b0;
		pins = {6'h3f, 26'h0, 16'h0};
		#3;
		forever
		begin
			#6;
			fclk = (fclk_run === 1'b1) ? ~fclk : 1'b0;
		end
	end

	// Hold one pin pattern for n core cycles
	task automatic hold(input fml_pins_t p, input int n);
		@(posedge mclk);
		pins <= p;
		repeat (n - 1) @(posedge mclk);
	endtask

	// Write strobe pulse carrying the word on the lines
	task automatic write_word(input fml_pins_t p, input logic [15:0] w);
		fml_pins_t q;
		q = p;
		q.we_n = 1'b0;
		q.ad = w;
		hold(q, 4);
		q.we_n = 1'b1;
		hold(q, 1);
	endtask

	// Released lines show the inverse, not a stale value
	task automatic free_lines(input fml_pins_t p, input int n);
		fml_pins_t q;
		q = p;
		q.ad = ~pins.ad;
		hold(q, n);
	endtask

	// Strobe low for four cycles, address changed after the first
	task automatic sync_read(input fml_pins_t p0, input fml_pins_t p1);
		fml_pins_t q;
		q = p1;
		q.addr_strobe_n = 1'b1;
		fclk_run = 1'b1;
		hold(p0, 1);
		hold(p1, 3);
		hold(q, 2);
		fclk_run = 1'b0;
	endtask
endmodule // fml_host_model

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the flash port
// Assumes: Host model drives pins; bench drives core side and config
// Notes: Outputs sampled on falling mclk edges
`timescale 1ns/100ps
`include "fml_regs.svh"

module tb_top;
	import fml_pkg::*;

	// --------------------------------------------------------------
	// Signals and instances
	// --------------------------------------------------------------
	localparam logic [25:0] M128 = (26'h1 << (`FML_TOP_128M + 1)) - 26'h1;
	localparam logic [25:0] M256 = (26'h1 << (`FML_TOP_256M + 1)) - 26'h1;
	logic mclk, rst_n, fclk, rd_valid, addr_stb, wr_stb, ad_oe, wait_o, wait_oe, standby;
	fml_pins_t pins, p, q;
	fml_cfg_t cfg;
	logic [15:0] rd_data, wr_data, ad_o;
	logic [25:0] addr_out;
	int errors, n_tests;

	fml_host_model u_host (.mclk(mclk), .pins(pins), .fclk(fclk));

	fml_flash_port u_dut (.mclk(mclk), .rst_n(rst_n), .fclk(fclk), .pins(pins), .cfg(cfg),
		.rd_data(rd_data), .rd_valid(rd_valid), .addr_out(addr_out), .addr_stb(addr_stb),
		.wr_data(wr_data), .wr_stb(wr_stb), .ad_o(ad_o), .ad_oe(ad_oe), .wait_o(wait_o),
		.wait_oe(wait_oe), .standby(standby));

	// Core clock, 100 ns
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic fml_pins_t idle();
		return {6'h3f, 26'h0, 16'h0};
	endfunction

	task automatic chk_word(input string what, input logic [25:0] exp, input logic [25:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Fixed window covers the pulse and catches a missing one
	task automatic wait_pulse(input bit wr, input logic exp);
		logic s;
		s = 1'b0;
		repeat (14)
		begin
			@(negedge mclk);
			if ((wr ? wr_stb : addr_stb) === 1'b1)
				s = 1'b1;
		end
		chk_bit(wr ? "write pulse" : "address pulse", exp, s);
	endtask

	task automatic set_cfg(input fml_bus_mode_t m, input logic s, input logic r, fml_density_t d);
		@(posedge mclk);
		cfg <= {m, s, r, d};
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Idle levels must hold from the very first edges after release
	task automatic t_reset();
		repeat (3)
		begin
			@(negedge mclk);
			chk_bit("standby", 1'b1, standby);
			chk_bit("ad_oe", 1'b0, ad_oe);
			chk_bit("wait_oe", 1'b0, wait_oe);
		end
	endtask

	task automatic t_async();
		set_cfg(FML_SPLIT, 1'b0, 1'b0, FML_D128M);
		p = idle();
		p.ce_n = 1'b0;
		p.addr_strobe_n = 1'b0;
		p.addr = 26'h3abcdef;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_word("flow addr", 26'h3abcdef & M128, addr_out);
		p.addr = 26'h1c0ffee;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_word("flow addr", 26'h1c0ffee & M128, addr_out);
		p.addr_strobe_n = 1'b1;
		u_host.hold(p, 1);
		wait_pulse(0, 1'b1);
		p.addr = 26'h0;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_word("held addr", 26'h1c0ffee & M128, addr_out);
		p.oe_n = 1'b0;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_bit("ad_oe", 1'b1, ad_oe);
		chk_word("ad_o", {10'h0, rd_data}, {10'h0, ad_o});
		chk_bit("wait_oe", 1'b1, wait_oe);
		chk_bit("wait_o", 1'b1, wait_o);
		@(posedge mclk);
		rd_valid <= 1'b1;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_bit("wait_o", 1'b0, wait_o);
		p.ce_n = 1'b1;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_bit("standby", 1'b1, standby);
		chk_bit("ad_oe", 1'b0, ad_oe);
		chk_bit("wait_oe", 1'b0, wait_oe);
		u_host.hold(idle(), 3);
	endtask

	task automatic t_mux();
		set_cfg(FML_AD_MUX, 1'b0, 1'b0, FML_D1G);
		p = idle();
		p.ce_n = 1'b0;
		p.addr_strobe_n = 1'b0;
		p.addr = 26'h2c50000;
		p.ad = 16'h1234;
		u_host.hold(p, 4);
		p.addr_strobe_n = 1'b1;
		u_host.hold(p, 1);
		wait_pulse(0, 1'b1);
		chk_word("mux addr", 26'h2c51234, addr_out);
		u_host.write_word(p, 16'h00ff);
		wait_pulse(1, 1'b1);
		chk_word("wr_data", 26'h00000ff, {10'h0, wr_data});
		p.oe_n = 1'b0;
		u_host.free_lines(p, 4);
		@(negedge mclk);
		chk_bit("ad_oe", 1'b1, ad_oe);
		chk_word("ad_o", {10'h0, rd_data}, {10'h0, ad_o});
		p.oe_n = 1'b1;
		p.frst_n = 1'b0;
		u_host.hold(p, 4);
		@(negedge mclk);
		chk_bit("ad_oe", 1'b0, ad_oe);
		u_host.write_word(p, 16'h0bad);
		wait_pulse(1, 1'b0);
		u_host.hold(idle(), 4);
	endtask

	task automatic t_sync(input logic r);
		set_cfg(FML_SPLIT, 1'b1, r, FML_D1G);
		p = idle();
		p.ce_n = 1'b0;
		p.addr_strobe_n = 1'b0;
		p.addr = 26'h1111111;
		q = p;
		q.addr = 26'h2222222;
		fork
			u_host.sync_read(p, q);
			wait_pulse(0, 1'b1);
		join
		chk_word("sync addr", r ? 26'h2222222 : 26'h1111111, addr_out);
		u_host.hold(idle(), 4);
	endtask

	task automatic t_two();
		set_cfg(FML_TWO_PHASE, 1'b1, 1'b1, FML_D1G);
		// Upper half is taken on link clock edges, so the frame starts here
		u_host.fclk_run = 1'b1;
		p = idle();
		p.ce_n = 1'b0;
		p.upper_addr_strobe_n = 1'b0;
		p.ad = 16'h0155;
		u_host.hold(p, 4);
		p.upper_addr_strobe_n = 1'b1;
		u_host.hold(p, 3);
		p.addr_strobe_n = 1'b0;
		p.ad = 16'h8765;
		q = p;
		q.ad = 16'h4321;
		fork
			u_host.sync_read(p, q);
			wait_pulse(0, 1'b1);
		join
		chk_word("two phase addr", {10'h155, 16'h8765}, addr_out);
		u_host.hold(idle(), 4);
	endtask

	// Two-phase with core-clock latching and a narrower density
	task automatic t_two_async();
		set_cfg(FML_TWO_PHASE, 1'b0, 1'b0, FML_D256M);
		p = idle();
		p.ce_n = 1'b0;
		p.upper_addr_strobe_n = 1'b0;
		p.ad = 16'h03ff;
		u_host.hold(p, 4);
		p.upper_addr_strobe_n = 1'b1;
		u_host.hold(p, 3);
		p.addr_strobe_n = 1'b0;
		p.ad = 16'hffff;
		u_host.hold(p, 4);
		p.addr_strobe_n = 1'b1;
		u_host.hold(p, 1);
		wait_pulse(0, 1'b1);
		chk_word("two phase async addr", {10'h3ff, 16'hffff} & M256, addr_out);
		u_host.hold(idle(), 4);
	endtask

	// --------------------------------------------------------------
	// Main sequence and watchdog
	// --------------------------------------------------------------
	initial
	begin
		errors = 0;
		n_tests = 0;
		rst_n = 1'b0;
		rd_valid = 1'b0;
		rd_data = 16'h5aa5;
		cfg = {FML_SPLIT, 1'b0, 1'b0, FML_D128M};
		u_host.fclk_run = 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		u_host.fclk_run = 1'b0;
		t_reset();
		t_async();
		t_mux();
		t_sync(1'b0);
		t_sync(1'b1);
		t_two();
		t_two_async();
		tally_and_finish();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#3000000;
		errors++;
		tally_and_finish();
	end
endmodule // tb_top
